// File: rtl/pwmpc_top.sv
// PWM pair join and prescaler clock halt control with AXI4-Lite registers
// Behaviour
// R1: Four join bits, each merging one pair of 8-bit channels into 16 bits.
// R2: Join bits of absent pairs ignore writes and read as zero.
// R3: Bit 7 joins channels 6 high and 7 low; clear means separate.
// R4: Bit 6 joins channels 4 high and 5 low; clear means separate.
// R5: Bit 5 joins channels 2 high and 3 low; clear means separate.
// R6: Bit 4 joins channels 0 high and 1 low; clear means separate.
// R7: Joined waveform leaves on low channel pin, using low channel settings.
// R8: Software changes a join bit only with both pair channels disabled.
// R9: Bit 3 set stops prescaler clock while processor is in wait.
// R10: Bit 2 set stops prescaler clock while part is in freeze.
// R11: Registers stay reachable in freeze; clock resumes on bit clear or exit.
// R12: Halted prescaler clock holds counters, counting resumes from held values.
// R13: Joined mode write to either counter byte resets whole 16-bit counter.
// R14: Software reads a joined counter with one 16-bit access; the code returns each counter byte in its own word read.
// R15: Joined low counter carries into high counter, compared to 16-bit values.
// R16: Control bits 1 and 0 read as zero and ignore writes.
`timescale 1ns/100ps

module pwmpc_top #(
  parameter logic [3:0] PAIR_PRESENT = 4'hF
) (
  // Clock and reset
  input  wire logic                         aclk,
  input  wire logic                         aresetn,
  // AXI4-Lite write address
  input  wire logic [pwmpc_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic [2:0]                   s_axi_awprot,
  input  wire logic                         s_axi_awvalid,
  output      logic                         s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [pwmpc_pkg::DATA_W-1:0] s_axi_wdata,
  input  wire logic [3:0]                   s_axi_wstrb,
  input  wire logic                         s_axi_wvalid,
  output      logic                         s_axi_wready,
  // AXI4-Lite write response
  output      logic [1:0]                   s_axi_bresp,
  output      logic                         s_axi_bvalid,
  input  wire logic                         s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [pwmpc_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic [2:0]                   s_axi_arprot,
  input  wire logic                         s_axi_arvalid,
  output      logic                         s_axi_arready,
  // AXI4-Lite read data
  output      logic [pwmpc_pkg::DATA_W-1:0] s_axi_rdata,
  output      logic [1:0]                   s_axi_rresp,
  output      logic                         s_axi_rvalid,
  input  wire logic                         s_axi_rready,
  // Processor mode status
  input  wire logic                         wait_mode,
  input  wire logic                         freeze_mode,
  // Per channel settings from the neighbouring registers
  input  wire logic [7:0]                   chan_enable,
  input  wire logic [7:0]                   chan_polarity,
  input  wire logic [7:0]                   chan_tick,
  input  wire logic [7:0][7:0]              chan_period,
  input  wire logic [7:0][7:0]              chan_duty,
  // Prescaler gate and waveforms
  output      logic                         prescaler_clock_enable,
  output      logic [7:0]                   pwm_output_port
);
  import pwmpc_pkg::*;

  pwmpc_state_s state_q;
  pwmpc_state_s state_d;

  // Word index of a byte address
  function automatic logic [5:0] reg_index(input logic [ADDR_W-1:0] addr);
    reg_index = addr[ADDR_W-1:2];
  endfunction

  // Mapped and aligned address check
  function automatic logic reg_mapped(input logic [ADDR_W-1:0] addr);
    logic [5:0] idx;
    idx = addr[ADDR_W-1:2];
    reg_mapped = (addr[1:0] == 2'h0) &&
                 ((idx == IDX_CTL) || ((idx >= IDX_CNT0) && (idx <= IDX_CNT7)));
  endfunction

  // Next count: wraps to zero at period minus one, zero period pins it
  function automatic logic [15:0] cnt_step(input logic [15:0] c,
                                           input logic [15:0] per);
    logic [16:0] nxt;
    nxt = {1'b0, c} + 17'h00001;
    if (nxt >= {1'b0, per}) begin
      cnt_step = 16'h0000;
    end else begin
      cnt_step = nxt[15:0];
    end
  endfunction

  // Left aligned waveform level from count, duty and polarity
  function automatic logic wave_level(input logic [15:0] c,
                                      input logic [15:0] duty,
                                      input logic        pol,
                                      input logic        en);
    if (!en) begin
      wave_level = 1'b0;
    end else if (pol) begin
      wave_level = (c < duty);
    end else begin
      wave_level = (c >= duty);
    end
  endfunction

  // Writable control bits: join bits of present pairs and the two halt bits
  function automatic logic [7:0] ctl_write_mask(input logic [3:0] present);
    ctl_write_mask = {present, CTL_LOW_MASK};
  endfunction

  // Outputs straight from the state register
  assign s_axi_awready          = state_q.aw_rdy;
  assign s_axi_wready           = state_q.w_rdy;
  assign s_axi_bresp            = state_q.bresp;
  assign s_axi_bvalid           = state_q.bvalid;
  assign s_axi_arready          = state_q.ar_rdy;
  assign s_axi_rdata            = state_q.rdata;
  assign s_axi_rresp            = state_q.rresp;
  assign s_axi_rvalid           = state_q.rvalid;
  assign prescaler_clock_enable = state_q.run;
  assign pwm_output_port        = state_q.pwm;

  // Next state of bus slave, control register, counters and waveforms
  always_comb begin
    logic              commit;
    logic              wr_ok;
    logic [5:0]        w_idx;
    logic [5:0]        r_idx;
    logic [7:0]        cnt_clr;
    logic [3:0]        joined;
    logic [15:0]       c16;
    logic [15:0]       per16;
    logic [15:0]       duty16;
    logic [15:0]       n16;
    logic [7:0]        cnt_rd;
    commit  = 1'b0;
    wr_ok   = 1'b0;
    w_idx   = 6'h00;
    r_idx   = 6'h00;
    cnt_clr = 8'h00;
    joined  = 4'h0;
    c16     = 16'h0000;
    per16   = 16'h0000;
    duty16  = 16'h0000;
    n16     = 16'h0000;
    cnt_rd  = 8'h00;
    state_d = state_q;

    // Capture write address and write data in either order
    if (s_axi_awvalid && state_q.aw_rdy) begin
      state_d.aw_have = 1'b1;
      state_d.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && state_q.w_rdy) begin
      state_d.w_have  = 1'b1;
      state_d.w_data  = s_axi_wdata[7:0];
      state_d.w_lane0 = s_axi_wstrb[0];
    end

    // Perform the write once both halves are held
    commit = state_q.aw_have && state_q.w_have && !state_q.bvalid;
    w_idx  = reg_index(state_q.aw_addr);
    wr_ok  = reg_mapped(state_q.aw_addr);
    if (commit) begin
      state_d.aw_have = 1'b0;
      state_d.w_have  = 1'b0;
      state_d.bvalid  = 1'b1;
      state_d.bresp   = wr_ok ? RESP_OKAY : RESP_SLVERR;
      if (wr_ok && state_q.w_lane0) begin
        if (w_idx == IDX_CTL) begin
          // Absent pair bits and bits 1..0 keep their zero
          state_d.ctl = state_q.w_data & ctl_write_mask(PAIR_PRESENT); // R2 R16
        end else begin
          // Any value written to a counter clears it
          cnt_clr[3'(w_idx - IDX_CNT0)] = 1'b1;
        end
      end
    end

    // Write response leaves on bready
    if (state_q.bvalid && s_axi_bready) begin
      state_d.bvalid = 1'b0;
    end
    state_d.aw_rdy = !state_d.aw_have && !state_d.bvalid;
    state_d.w_rdy  = !state_d.w_have && !state_d.bvalid;

    // Read: register data one cycle after the address is taken
    r_idx = reg_index(s_axi_araddr);
    if (r_idx >= IDX_CNT0 && r_idx <= IDX_CNT7) begin
      cnt_rd = state_q.cnt[3'(r_idx - IDX_CNT0)];
    end
    if (s_axi_arvalid && state_q.ar_rdy) begin
      state_d.rvalid = 1'b1;
      if (!reg_mapped(s_axi_araddr)) begin
        state_d.rdata = '0;
        state_d.rresp = RESP_SLVERR;
      end else if (r_idx == IDX_CTL) begin
        state_d.rdata = {24'h000000, state_q.ctl}; // R16
        state_d.rresp = RESP_OKAY;
      end else begin
        state_d.rdata = {24'h000000, cnt_rd};
        state_d.rresp = RESP_OKAY;
      end
    end
    if (state_q.rvalid && s_axi_rready) begin
      state_d.rvalid = 1'b0;
    end
    state_d.ar_rdy = !state_d.rvalid;

    // Prescaler clock gate from wait and freeze halts
    state_d.run = !(state_q.ctl[CTL_HALT_WAIT] && wait_mode) && // R9
                  !(state_q.ctl[CTL_HALT_FRZ] && freeze_mode);  // R10 R11

    // Join bits; pair p joins channel 2p high and 2p+1 low
    joined = state_q.ctl[CTL_JOIN_LSB +: NUM_PAIRS] & PAIR_PRESENT; // R1 R3 R4 R5 R6

    // Counters and waveforms, one pair at a time
    for (int p = 0; p < NUM_PAIRS; p++) begin
      if (joined[p]) begin
        // Joined pair runs as one 16-bit counter, low byte settings rule
        c16    = {state_q.cnt[2*p], state_q.cnt[2*p+1]};       // R15
        per16  = {chan_period[2*p], chan_period[2*p+1]};       // R15
        duty16 = {chan_duty[2*p], chan_duty[2*p+1]};           // R15
        n16    = c16;
        if (cnt_clr[2*p] || cnt_clr[2*p+1]) begin
          n16 = 16'h0000;                                      // R13
        end else if (state_q.run && chan_enable[2*p+1] &&
                     chan_tick[2*p+1]) begin
          n16 = cnt_step(c16, per16);                          // R7 R12 R15
        end
        state_d.cnt[2*p]   = n16[15:8];
        state_d.cnt[2*p+1] = n16[7:0];
        // Waveform on the low channel pin, high channel pin idle
        state_d.pwm[2*p+1] = wave_level(c16, duty16,
                                        chan_polarity[2*p+1],
                                        chan_enable[2*p+1]);   // R7
        state_d.pwm[2*p]   = 1'b0;                             // R7
      end else begin
        // Separate 8-bit channels
        for (int h = 0; h < 2; h++) begin
          c16    = {8'h00, state_q.cnt[2*p+h]};
          per16  = {8'h00, chan_period[2*p+h]};
          duty16 = {8'h00, chan_duty[2*p+h]};
          n16    = c16;
          if (cnt_clr[2*p+h]) begin
            n16 = 16'h0000;
          end else if (state_q.run && chan_enable[2*p+h] &&
                       chan_tick[2*p+h]) begin
            n16 = cnt_step(c16, per16);                        // R12
          end
          state_d.cnt[2*p+h] = n16[7:0];
          state_d.pwm[2*p+h] = wave_level(c16, duty16,
                                          chan_polarity[2*p+h],
                                          chan_enable[2*p+h]);
        end
      end
    end
  end

  // State register with synchronous reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q         <= '0;
      state_q.ctl     <= CTL_RESET;
      state_q.cnt     <= {NUM_CH{CNT_RESET}};
      state_q.bresp   <= RESP_OKAY;
      state_q.rresp   <= RESP_OKAY;
    end else begin
      state_q <= state_d;
    end
  end

endmodule

// File: rtl/pwmpc_pkg.sv
// Constants, register map and state layout of the PWM pair join and clock halt block
package pwmpc_pkg;

  // Channel and pair counts
  localparam int unsigned NUM_CH    = 8;
  localparam int unsigned NUM_PAIRS = 4;

  // Bus widths
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;

  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_CTL  = 6'h05;
  localparam logic [5:0] IDX_CNT0 = 6'h0C;
  localparam logic [5:0] IDX_CNT7 = 6'h13;

  // Control register fields
  localparam int unsigned CTL_JOIN_LSB  = 4;
  localparam int unsigned CTL_HALT_WAIT = 3;
  localparam int unsigned CTL_HALT_FRZ  = 2;
  localparam logic [7:0]  CTL_RESET     = 8'h00;
  localparam logic [3:0]  CTL_LOW_MASK  = 4'hC;

  // Counter reset value
  localparam logic [7:0] CNT_RESET = 8'h00;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Complete state of the block
  typedef struct packed {
    logic [7:0]                ctl;
    logic [NUM_CH-1:0][7:0]    cnt;
    logic [NUM_CH-1:0]         pwm;
    logic                      run;
    logic                      aw_rdy;
    logic                      aw_have;
    logic [ADDR_W-1:0]         aw_addr;
    logic                      w_rdy;
    logic                      w_have;
    logic [7:0]                w_data;
    logic                      w_lane0;
    logic                      bvalid;
    logic [1:0]                bresp;
    logic                      ar_rdy;
    logic                      rvalid;
    logic [DATA_W-1:0]         rdata;
    logic [1:0]                rresp;
  } pwmpc_state_s;

endpackage

// File: verification/pwmpc_checker.sv
// Port level assertions for the pair join and clock halt block
`timescale 1ns/100ps
module pwmpc_checker (
  // Clock and reset
  input wire logic                         aclk,
  input wire logic                         aresetn,
  // Bus handshakes
  input wire logic                         s_axi_awvalid,
  input wire logic                         s_axi_awready,
  input wire logic                         s_axi_wvalid,
  input wire logic                         s_axi_wready,
  input wire logic                         s_axi_bvalid,
  input wire logic                         s_axi_bready,
  input wire logic                         s_axi_arvalid,
  input wire logic                         s_axi_arready,
  input wire logic [pwmpc_pkg::DATA_W-1:0] s_axi_rdata,
  input wire logic                         s_axi_rvalid,
  input wire logic                         s_axi_rready,
  // Modes, settings and outputs
  input wire logic                         wait_mode,
  input wire logic                         freeze_mode,
  input wire logic [7:0]                   chan_enable,
  input wire logic                         prescaler_clock_enable,
  input wire logic [7:0]                   pwm_output_port
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Prescaler runs whenever neither halting mode is active
  property p_run; !wait_mode && !freeze_mode |=> prescaler_clock_enable; endproperty
  a_run: assert property (p_run) else $error("prescaler gated without mode");
  // Bus handshakes and answers
  property p_aw; s_axi_awvalid && s_axi_awready |=> !s_axi_awready; endproperty
  a_aw: assert property (p_aw) else $error("awready stayed high");
  property p_wr; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid; endproperty
  a_wr: assert property (p_wr) else $error("write answer late");
  property p_bdrop; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid ##1 (s_axi_awready && s_axi_wready); endproperty
  a_bdrop: assert property (p_bdrop) else $error("write channel not reopened");
  property p_rd; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready; endproperty
  a_rd: assert property (p_rd) else $error("read answer late");
  property p_rdrop; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid ##1 s_axi_arready; endproperty
  a_rdrop: assert property (p_rdrop) else $error("read channel not reopened");
  property p_rhi; s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000; endproperty
  a_rhi: assert property (p_rhi) else $error("upper read bits set");
  // All channels disabled for three cycles keep every pin low
  property p_off; chan_enable == 8'h00 [*3] |-> pwm_output_port == 8'h00; endproperty
  a_off: assert property (p_off) else $error("pin active while disabled");
endmodule

bind pwmpc_top pwmpc_checker u_checker (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .wait_mode, .freeze_mode, .chan_enable,
  .prescaler_clock_enable, .pwm_output_port);

// File: verification/pwmpc_top_bench.sv
// Self-checking bench for the pair join and clock halt block
`timescale 1ns/100ps
module pwmpc_top_bench;
  import pwmpc_pkg::*;
  logic aclk = 1'b0, aresetn = 1'b0, wait_mode = 1'b0, freeze_mode = 1'b0;
  logic [ADDR_W-1:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [DATA_W-1:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic prescaler_clock_enable;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic [7:0] chan_enable = 8'h00, chan_polarity = 8'h00, chan_tick = 8'h00, pwm_output_port;
  logic [7:0][7:0] chan_period = '0, chan_duty = '0;
  int n_mismatch = 0, compares = 0, cycles = 0;

  pwmpc_top u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0),
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .wait_mode, .freeze_mode, .chan_enable, .chan_polarity, .chan_tick, .chan_period,
    .chan_duty, .prescaler_clock_enable, .pwm_output_port);

  // Clock and hang guard
  initial begin
    forever #5 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_mismatch++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  // Write with both channels offered together; response kept in rs
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  // Read one word, then compare it
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string what);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
    chk(rd, exp, what);
  endtask

  task automatic t_regs();
    rdc(8'h14, 32'h0, "control reset");
    wr(8'h14, 32'hFF);
    chk({30'h0, rs}, {30'h0, RESP_OKAY}, "write resp");
    rdc(8'h14, 32'hFC, "all join and halt bits");
    for (int p = 0; p < 4; p++) begin
      wr(8'h14, 32'h10 << p);
      rdc(8'h14, 32'h10 << p, "one join bit");
    end
    rdc(8'h00, 32'h0, "unmapped data");
    chk({30'h0, rs}, {30'h0, RESP_SLVERR}, "unmapped resp");
    $display("test registers done");
  endtask

  task automatic t_halt();
    wr(8'h14, 32'h08);
    wait_mode <= 1'b1;
    repeat (3) @(posedge aclk);
    chk(prescaler_clock_enable, 32'h0, "wait halt");
    wait_mode <= 1'b0;
    repeat (3) @(posedge aclk);
    chk(prescaler_clock_enable, 32'h1, "wait over");
    freeze_mode <= 1'b1;
    repeat (3) @(posedge aclk);
    chk(prescaler_clock_enable, 32'h1, "freeze without halt bit");
    freeze_mode <= 1'b0;
    wr(8'h14, 32'h04);
    wait_mode <= 1'b1;
    repeat (3) @(posedge aclk);
    chk(prescaler_clock_enable, 32'h1, "wait without halt bit");
    wait_mode <= 1'b0;
    freeze_mode <= 1'b1;
    repeat (3) @(posedge aclk);
    chk(prescaler_clock_enable, 32'h0, "freeze halt");
    rdc(8'h14, 32'h04, "read in freeze");
    wr(8'h14, 32'h00);
    repeat (3) @(posedge aclk);
    chk(prescaler_clock_enable, 32'h1, "halt bit cleared");
    freeze_mode <= 1'b0;
    $display("test clock halt done");
  endtask

  // Pulse the low channel tick for n cycles
  task automatic ticks(input int n);
    chan_tick <= 8'h02;
    repeat (n) @(posedge aclk);
    chan_tick <= 8'h00;
    repeat (3) @(posedge aclk);
  endtask

  task automatic t_join();
    wr(8'h14, 32'h10);
    chan_period[0] <= 8'h02;
    chan_duty[0] <= 8'h01;
    chan_duty[1] <= 8'h80;
    chan_polarity <= 8'h02;
    chan_enable <= 8'h02;
    repeat (2) @(posedge aclk);
    ticks(259);
    chk(pwm_output_port[1:0], 32'h2, "joined pins");
    rdc(8'h30, 32'h01, "high byte");
    rdc(8'h34, 32'h03, "low byte");
    wr(8'h14, 32'h14);
    freeze_mode <= 1'b1;
    repeat (3) @(posedge aclk);
    ticks(10);
    rdc(8'h34, 32'h03, "held in freeze");
    freeze_mode <= 1'b0;
    repeat (3) @(posedge aclk);
    ticks(2);
    rdc(8'h34, 32'h05, "resumed count");
    wr(8'h34, 32'hA5);
    rdc(8'h30, 32'h00, "high cleared");
    rdc(8'h34, 32'h00, "low cleared");
    chan_enable <= 8'h00;
    $display("test joined counter done");
  endtask

  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    t_regs();
    t_halt();
    t_join();
    give_verdict();
  end
endmodule
